// ---- verilog/rff_defines.svh ----
`ifndef RFF_DEFINES_SVH
`define RFF_DEFINES_SVH

// Register byte offsets on the APB side.
`define RFF_OFF_CTRL      8'h00
`define RFF_OFF_MAC_LO    8'h04
`define RFF_OFF_MAC_HI    8'h08
`define RFF_OFF_MAXLEN    8'h0C
`define RFF_OFF_STATUS    8'h10
`define RFF_OFF_COUNT     8'h14

// Filter control: eight implemented enables, upper bits read as zero.
`define RFF_CTRL_W        8
`define RFF_CTRL_RST      8'h59
`define RFF_MAXLEN_RST    16'h05EE

// Status and count register field positions.
`define RFF_ST_ACCEPT     0
`define RFF_ST_REASON_LO  4
`define RFF_ST_LEN_LO     16
`define RFF_CNT_DROP_LO   16

// Frame geometry, counted in bytes.
`define RFF_DA_BYTES      6
`define RFF_RUNT_MIN      16'h0040
`define RFF_HDR_PLUS_MIN  16'h0046

// Reflected CRC-32 constants; the residue is left after the FCS passes.
`define RFF_CRC_POLY      32'hEDB88320
`define RFF_CRC_INIT      32'hFFFFFFFF
`define RFF_CRC_RESIDUE   32'hDEBB20E3

`endif

// ---- verilog/rff_pkg.sv ----
`default_nettype none

package rff_pkg;

    // One byte of the receive stream from the MAC; sof marks the first
    // destination address byte, eof the last check sequence byte.
    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic [7:0] data;
    } rff_rx_s;

    // Filter enables in control register bit order, bit 7 first.
    typedef struct packed {
        logic crc_error_collect_enable;
        logic crc_error_reject_enable;
        logic short_frame_collect_enable;
        logic short_frame_reject_enable;
        logic own_address_collect_enable;
        logic foreign_unicast_collect_enable;
        logic group_address_collect_enable;
        logic all_stations_collect_enable;
    } rff_ctl_s;

    // Which filter settled the fate of a frame.
    typedef enum logic [3:0] {
        RFF_R_NONE,
        RFF_R_CRC_COLLECT,
        RFF_R_SHORT_COLLECT,
        RFF_R_CRC_REJECT,
        RFF_R_SHORT_REJECT,
        RFF_R_OWN,
        RFF_R_FOREIGN,
        RFF_R_GROUP,
        RFF_R_ALL
    } rff_reason_e;

    // Verdict handed to the buffer write logic.
    typedef struct packed {
        logic        done;
        logic        accept;
        rff_reason_e reason;
        logic [15:0] len;
    } rff_verdict_s;

    typedef enum logic [1:0] {
        RFF_S_IDLE,
        RFF_S_RECV,
        RFF_S_DECIDE
    } rff_state_e;

endpackage : rff_pkg

`default_nettype wire

// ---- verilog/rff_crc32.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rff_defines.svh"

module rff_crc32 (
    // Clock, reset and enable.
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic        ce_i,
    // Byte stream.
    input  wire logic        start_i,
    input  wire logic        en_i,
    input  wire logic [7:0]  data_i,
    // Running remainder.
    output logic      [31:0] crc_o
);

    // Bitwise byte update; the loop unrolls into an XOR tree.
    function automatic logic [31:0] rff_crc_byte(input logic [31:0] c_in,
                                                 input logic [7:0]  d);
        logic [31:0] c;
        c = c_in ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `RFF_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : rff_crc_byte

    // The first byte of a frame folds into the seed, so no idle cycle
    // is needed between back to back frames.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            crc_o <= `RFF_CRC_INIT;
        end else if (ce_i && en_i) begin
            crc_o <= rff_crc_byte(start_i ? `RFF_CRC_INIT : crc_o, data_i);
        end
    end

endmodule : rff_crc32
`default_nettype wire

// ---- verilog/rff_top.sv ----
// Operation
// - CRC reject enable discards bad-FCS frames.
// - Short collect accepts frames of 69 bytes or fewer.
// - Short reject discards 69-byte-or-fewer frames.
// - Own-address collect accepts exact station address match.
// - Foreign unicast collect accepts other unicast addresses.
// - Group collect accepts multicast destination addresses.
// - All-stations collect accepts all-ones destination.
// - Rejection filters override address collection.
// - CRC and short collection filters override rejection filters.
// - CRC collect accepts frames whose check fails.
// - Both collection enables clear after reset.
// - Length counts source address through FCS.
// - Frames over maximum length are truncated.
// - CRC reject, short reject, own-address, all-stations set after reset.
// - A disabled filter passes every frame on.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rff_defines.svh"

module rff_top #(
    parameter int CNT_W = 16
) (
    // Clock, reset and enable.
    input  wire logic                  mclk_i,
    input  wire logic                  nrst_i,
    input  wire logic                  ce_i,
    // APB slave.
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [7:0]            paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    // Receive stream and verdict.
    input  wire rff_pkg::rff_rx_s      rx_i,
    output rff_pkg::rff_verdict_s      verdict_o
);
    import rff_pkg::*;

    // Counters share one 32-bit count word, so 16 bits is the limit.
    if (CNT_W < 1 || CNT_W > 16) begin : g_chk
        $error("CNT_W must lie between 1 and 16");
    end

    logic [`RFF_CTRL_W-1:0] ctl_q;
    rff_ctl_s               ctl;
    logic [47:0]            mac_q;
    logic [15:0]            maxlen_q;
    logic [7:0]             da_q [`RFF_DA_BYTES];
    logic [47:0]            da_w;
    logic [15:0]            cnt_q;
    rff_state_e             state_q;
    logic [31:0]            crc;
    logic [CNT_W-1:0]       n_acc_q;
    logic [CNT_W-1:0]       n_drop_q;
    logic                   acc_phase;
    logic                   wr_fire;
    logic                   addr_hit;
    logic [31:0]            rd_d;
    logic                   start;
    logic                   take;
    logic                   ending;
    logic [15:0]            idx;
    logic                   crc_bad;
    logic                   short_frm;
    logic                   own_hit;
    logic                   grp_bit;
    logic                   all_hit;
    logic                   accept_d;
    rff_reason_e            reason_d;
    logic                   deciding;

    assign ctl = rff_ctl_s'(ctl_q);

    // APB access phase; the slave inserts one wait state on every access.
    assign acc_phase = psel_i && penable_i;
    assign wr_fire   = acc_phase && pready_o && pwrite_i && addr_hit;

    // Address decode and read mux.
    always_comb begin
        addr_hit = 1'b1;
        rd_d     = 32'h00000000;
        unique case (paddr_i)
            `RFF_OFF_CTRL:   rd_d[`RFF_CTRL_W-1:0] = ctl_q;
            `RFF_OFF_MAC_LO: rd_d = mac_q[31:0];
            `RFF_OFF_MAC_HI: rd_d[15:0] = mac_q[47:32];
            `RFF_OFF_MAXLEN: rd_d[15:0] = maxlen_q;
            `RFF_OFF_STATUS: begin
                rd_d[`RFF_ST_ACCEPT] = verdict_o.accept;
                rd_d[`RFF_ST_REASON_LO +: 4] = verdict_o.reason;
                rd_d[`RFF_ST_LEN_LO +: 16] = verdict_o.len;
            end
            `RFF_OFF_COUNT: begin
                rd_d[CNT_W-1:0] = n_acc_q;
                rd_d[`RFF_CNT_DROP_LO +: CNT_W] = n_drop_q;
            end
            default: addr_hit = 1'b0;
        endcase
    end

    // Handshake: ready and read data are registered, so prdata holds
    // steady for the whole cycle in which the master samples it.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end else if (ce_i) begin
            if (acc_phase && !pready_o) begin
                pready_o  <= 1'b1;
                pslverr_o <= !addr_hit;
                prdata_o  <= pwrite_i ? 32'h00000000 : rd_d;
            end else begin
                pready_o  <= 1'b0;
                pslverr_o <= 1'b0;
            end
        end
    end

    // Software-written configuration.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctl_q    <= `RFF_CTRL_RST;
            mac_q    <= 48'h000000000000;
            maxlen_q <= `RFF_MAXLEN_RST;
        end else if (ce_i && wr_fire) begin
            unique case (paddr_i)
                `RFF_OFF_CTRL:   ctl_q <= pwdata_i[`RFF_CTRL_W-1:0];
                `RFF_OFF_MAC_LO: mac_q[31:0] <= pwdata_i;
                `RFF_OFF_MAC_HI: mac_q[47:32] <= pwdata_i[15:0];
                `RFF_OFF_MAXLEN: maxlen_q <= pwdata_i[15:0];
                default: ;
            endcase
        end
    end

    // A sof restarts the frame even mid-frame, so a lost eof costs one
    // frame and never wedges the filter.
    assign start  = rx_i.valid && rx_i.sof;
    assign idx    = start ? 16'h0000 : cnt_q;
    assign take   = rx_i.valid && (start || state_q == RFF_S_RECV)
                    && (idx < maxlen_q);
    assign ending = rx_i.valid && rx_i.eof
                    && (start || state_q == RFF_S_RECV);

    // Frame sequencing.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= RFF_S_IDLE;
        end else if (ce_i) begin
            if (ending) begin
                state_q <= RFF_S_DECIDE;
            end else if (start) begin
                state_q <= RFF_S_RECV;
            end else if (state_q == RFF_S_DECIDE) begin
                state_q <= RFF_S_IDLE;
            end
        end
    end

    // Byte count stops at the maximum; later bytes are dropped, which
    // also starves the CRC of the FCS.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 16'h0000;
        end else if (ce_i && take) begin
            cnt_q <= idx + 16'h0001;
        end else if (ce_i && start) begin
            cnt_q <= 16'h0000;
        end
    end

    // Destination address capture, one register per byte.
    for (genvar g = 0; g < `RFF_DA_BYTES; g++) begin : g_da
        always_ff @(posedge mclk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                da_q[g] <= 8'h00;
            end else if (ce_i && take && idx == 16'(g)) begin
                da_q[g] <= rx_i.data;
            end
        end
        assign da_w[8*g +: 8] = da_q[g];
    end

    rff_crc32 u_crc (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .ce_i    (ce_i),
        .start_i (start),
        .en_i    (take),
        .data_i  (rx_i.data),
        .crc_o   (crc)
    );

    // Frame properties, valid in the decide cycle.
    assign deciding  = state_q == RFF_S_DECIDE;
    assign crc_bad   = crc != `RFF_CRC_RESIDUE;
    assign short_frm = cnt_q < `RFF_HDR_PLUS_MIN;
    assign own_hit   = da_w == mac_q;
    assign grp_bit   = da_w[0];
    assign all_hit   = &da_w;

    // Filter chain in priority order; a clear enable just falls through.
    always_comb begin
        accept_d = 1'b0;
        reason_d = RFF_R_NONE;
        if (ctl.crc_error_collect_enable && crc_bad) begin
            accept_d = 1'b1;
            reason_d = RFF_R_CRC_COLLECT;
        end else if (ctl.short_frame_collect_enable && short_frm) begin
            accept_d = 1'b1;
            reason_d = RFF_R_SHORT_COLLECT;
        end else if (ctl.crc_error_reject_enable && crc_bad) begin
            reason_d = RFF_R_CRC_REJECT;
        end else if (ctl.short_frame_reject_enable && short_frm) begin
            reason_d = RFF_R_SHORT_REJECT;
        end else if (ctl.own_address_collect_enable && own_hit) begin
            accept_d = 1'b1;
            reason_d = RFF_R_OWN;
        end else if (ctl.foreign_unicast_collect_enable && !grp_bit
                     && !own_hit) begin
            accept_d = 1'b1;
            reason_d = RFF_R_FOREIGN;
        end else if (ctl.group_address_collect_enable && grp_bit) begin
            accept_d = 1'b1;
            reason_d = RFF_R_GROUP;
        end else if (ctl.all_stations_collect_enable && all_hit) begin
            accept_d = 1'b1;
            reason_d = RFF_R_ALL;
        end
    end

    // Verdict register; done pulses once, the rest holds until the next.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            verdict_o <= '0;
        end else if (ce_i) begin
            verdict_o.done <= deciding;
            if (deciding) begin
                verdict_o.accept <= accept_d;
                verdict_o.reason <= reason_d;
                verdict_o.len    <= short_frm && cnt_q < 16'(`RFF_DA_BYTES)
                                    ? 16'h0000
                                    : cnt_q - 16'(`RFF_DA_BYTES);
            end
        end
    end

    // Statistics; they wrap rather than saturate.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            n_acc_q  <= '0;
            n_drop_q <= '0;
        end else if (ce_i && deciding) begin
            if (accept_d) begin
                n_acc_q <= n_acc_q + CNT_W'(1);
            end else begin
                n_drop_q <= n_drop_q + CNT_W'(1);
            end
        end
    end

    // Checks below watch design state along with ce_i, rx_i and the APB inputs.
    logic wr_seen_q;
    logic col_hit;
    logic rej_hit;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_seen_q <= 1'b0;
        end else if (ce_i && wr_fire && paddr_i == `RFF_OFF_CTRL) begin
            wr_seen_q <= 1'b1;
        end
    end

    assign col_hit = (ctl.crc_error_collect_enable && crc_bad)
                     || (ctl.short_frame_collect_enable && short_frm);
    assign rej_hit = (ctl.crc_error_reject_enable && crc_bad)
                     || (ctl.short_frame_reject_enable && short_frm);

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_decide;
        ce_i && deciding;
    endsequence

    sequence s_kept;
        verdict_o.done && verdict_o.accept;
    endsequence

    sequence s_dropped;
        verdict_o.done && !verdict_o.accept;
    endsequence

    property p_crc_reject;
        s_decide and (ctl.crc_error_reject_enable && crc_bad && !col_hit)
        |=> s_dropped ##0 verdict_o.reason == RFF_R_CRC_REJECT;
    endproperty
    a_crc_reject: assert property (p_crc_reject)
        else $error("bad-CRC frame was not rejected");

    property p_short_collect;
        s_decide and (ctl.short_frame_collect_enable && short_frm)
        |=> s_kept;
    endproperty
    a_short_collect: assert property (p_short_collect)
        else $error("short frame was not collected");

    property p_short_reject;
        s_decide and (ctl.short_frame_reject_enable && short_frm
                      && !col_hit)
        |=> s_dropped;
    endproperty
    a_short_reject: assert property (p_short_reject)
        else $error("short frame was not rejected");

    property p_own;
        s_decide and (ctl.own_address_collect_enable && own_hit
                      && !rej_hit && !col_hit)
        |=> s_kept ##0 verdict_o.reason == RFF_R_OWN;
    endproperty
    a_own: assert property (p_own)
        else $error("own-address frame not accepted");

    property p_group;
        s_decide and (ctl.group_address_collect_enable && grp_bit
                      && !rej_hit)
        |=> s_kept;
    endproperty
    a_group: assert property (p_group)
        else $error("multicast frame not accepted");

    property p_all;
        s_decide and (ctl.all_stations_collect_enable && all_hit
                      && !rej_hit)
        |=> s_kept;
    endproperty
    a_all: assert property (p_all)
        else $error("broadcast frame not accepted");

    property p_crc_collect;
        s_decide and (ctl.crc_error_collect_enable && crc_bad)
        |=> s_kept ##0 verdict_o.reason == RFF_R_CRC_COLLECT;
    endproperty
    a_crc_collect: assert property (p_crc_collect)
        else $error("bad-CRC frame not collected");

    property p_reset_enables;
        !wr_seen_q |-> ctl_q == `RFF_CTRL_RST;
    endproperty
    a_reset_enables: assert property (p_reset_enables)
        else $error("filter enables left their reset value");

    property p_all_off;
        s_decide and (ctl_q == '0) |=> s_dropped ##0
                                      verdict_o.reason == RFF_R_NONE;
    endproperty
    a_all_off: assert property (p_all_off)
        else $error("frame accepted with every filter disabled");

    property p_truncate;
        ce_i && rx_i.valid && !start && state_q == RFF_S_RECV
        && cnt_q >= maxlen_q |=> $stable(crc) && $stable(cnt_q);
    endproperty
    a_truncate: assert property (p_truncate)
        else $error("byte past maximum length was taken");

    property p_apb_wait;
        ce_i && psel_i && !penable_i ##1 ce_i && acc_phase
        |=> pready_o;
    endproperty
    a_apb_wait: assert property (p_apb_wait)
        else $error("APB access was not answered after one wait");

endmodule : rff_top
`default_nettype wire

// ---- testbench/rff_rx_source.sv ----
`timescale 1ns/1ps
`default_nettype none

module rff_rx_source
    import rff_pkg::*;
(
    // Clock.
    input  wire logic       mclk_i,
    // Byte stream towards the filter chain.
    output rff_pkg::rff_rx_s rx_o
);

    // Idle until the first frame is sent.
    initial begin
        rx_o = '0;
    end

    // One step of the reflected CRC-32 over a byte.
    function automatic logic [31:0] crc_step(input logic [31:0] c,
                                             input logic [7:0]  d);
        logic [31:0] r;
        r = c ^ {24'h0, d};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ 32'hEDB88320) : (r >> 1);
        end
        return r;
    endfunction : crc_step

    // Sends n bytes after a rising edge, FCS last and low byte first.
    // Between frames the data lines show the inverse of the last byte, so
    // a design that samples stale data cannot pass by luck.
    task automatic send_frame(input logic [47:0] da,
                              input int          n,
                              input logic        bad);
        logic [7:0]  b [$];
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        for (int i = 0; i < n - 4; i++) begin
            b.push_back(i < 6 ? da[8*i +: 8] : 8'(i) ^ 8'hA5);
            c = crc_step(c, b[i]);
        end
        c = ~c;
        for (int i = 0; i < 4; i++) begin
            b.push_back(c[8*i +: 8]);
        end
        if (bad) begin
            b[n-4] = b[n-4] ^ 8'h01;
        end
        foreach (b[i]) begin
            rx_o <= '{1'b1, i == 0, i == n - 1, b[i]};
            @(posedge mclk_i);
        end
        rx_o <= '{1'b0, 1'b0, 1'b0, ~b[n-1]};
    endtask : send_frame

endmodule : rff_rx_source

`default_nettype wire

// ---- testbench/rff_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rff_defines.svh"

module rff_top_test;
    import rff_pkg::*;

    localparam logic [47:0] DA_OWN   = 48'h554433221102;
    localparam logic [47:0] DA_OTHER = 48'h564433221102;
    localparam logic [47:0] DA_GROUP = 48'h0100005E0001;
    localparam logic [47:0] DA_BCAST = 48'hFFFFFFFFFFFF;

    logic         mclk_i;
    logic         nrst_i;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [7:0]   paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    rff_rx_s      rx;
    rff_verdict_s verdict;
    int           n_fail = 0;
    int           checks_done = 0;
    int           cycles = 0;
    int           n_acc = 0;
    int           n_drop = 0;
    int           max_len = 1518;

    rff_top #(.CNT_W(16)) dut (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr),
        .rx_i(rx), .verdict_o(verdict)
    );

    rff_rx_source src (.mclk_i(mclk_i), .rx_o(rx));

    // Free-running 20 MHz clock.
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // A hang in any wait ends up here instead of running forever.
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            $display("unexpected timeout: expected finish, seen hang");
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        @(posedge mclk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        // Ready is looked at as the edge samples it, so the write lands
        // and the read data are taken at this very edge.
        do begin
            @(posedge mclk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rdc(input string what, input logic [7:0] a,
                       input logic [31:0] exp, input logic [31:0] mask,
                       input logic experr);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(what, exp & mask, r & mask);
        chk({what, " error"}, {31'h0, experr}, {31'h0, e});
    endtask : rdc

    // Sets the enables, sends one frame and checks verdict and status.
    task automatic run_case(input logic [7:0] ctl, input logic [47:0] da,
                            input int n, input logic bad, input logic acc,
                            input rff_reason_e why);
        logic [15:0] len;
        len = 16'((n < max_len ? n : max_len) - 6);
        wr(`RFF_OFF_CTRL, {24'h0, ctl});
        @(posedge mclk_i);
        src.send_frame(da, n, bad);
        for (int k = 0; k < 8 && verdict.done !== 1'b1; k++) begin
            @(posedge mclk_i);
            #1;
        end
        chk("verdict done", 32'h1, {31'h0, verdict.done});
        chk("verdict accept", {31'h0, acc}, {31'h0, verdict.accept});
        chk("verdict reason", {28'h0, why}, {28'h0, verdict.reason});
        chk("verdict length", {16'h0, len}, {16'h0, verdict.len});
        rdc("status", `RFF_OFF_STATUS, {len, 8'h0, why, 3'h0, acc},
            32'hFFFF00F1, 1'b0);
        if (acc) n_acc++;
        else n_drop++;
    endtask : run_case

    // Main sequence: reset, register checks, then one frame per case.
    initial begin
        nrst_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge mclk_i);
        nrst_i <= 1'b1;
        rdc("control", `RFF_OFF_CTRL, 32'h59, '1, 1'b0);
        rdc("max length", `RFF_OFF_MAXLEN, 32'h5EE, 32'hFFFF, 1'b0);
        rdc("unmapped", 8'h18, 32'h0, '1, 1'b1);
        wr(`RFF_OFF_MAC_LO, 32'h33221102);
        wr(`RFF_OFF_MAC_HI, 32'h00005544);
        rdc("station low", `RFF_OFF_MAC_LO, 32'h33221102, '1, 1'b0);
        rdc("station high", `RFF_OFF_MAC_HI, 32'h00005544, '1, 1'b0);
        run_case(8'h59, DA_OWN, 70, 0, 1, RFF_R_OWN);
        run_case(8'h59, DA_OWN, 69, 0, 0,
                 RFF_R_SHORT_REJECT);
        run_case(8'h59, DA_OWN, 70, 1, 0, RFF_R_CRC_REJECT);
        run_case(8'h59, DA_OTHER, 70, 0, 0, RFF_R_NONE);
        run_case(8'h59, DA_BCAST, 70, 0, 1, RFF_R_ALL);
        run_case(8'h41, DA_BCAST, 70, 1, 0, RFF_R_CRC_REJECT);
        run_case(8'h04, DA_OTHER, 70, 0, 1, RFF_R_FOREIGN);
        run_case(8'h04, DA_OWN, 70, 0, 0, RFF_R_NONE);
        run_case(8'h04, DA_GROUP, 70, 0, 0, RFF_R_NONE);
        run_case(8'h02, DA_GROUP, 70, 0, 1, RFF_R_GROUP);
        run_case(8'h02, DA_OTHER, 70, 0, 0, RFF_R_NONE);
        run_case(8'hC8, DA_OWN, 70, 1, 1,
                 RFF_R_CRC_COLLECT);
        run_case(8'h80, DA_OWN, 70, 0, 0, RFF_R_NONE);
        run_case(8'h30, DA_OTHER, 69, 0, 1,
                 RFF_R_SHORT_COLLECT);
        run_case(8'h20, DA_OWN, 70, 0, 0, RFF_R_NONE);
        run_case(8'hA0, DA_OTHER, 40, 1, 1, RFF_R_CRC_COLLECT);
        run_case(8'h00, DA_BCAST, 20, 1, 0, RFF_R_NONE);
        // A good frame cut short by the length limit loses its FCS.
        wr(`RFF_OFF_MAXLEN, 32'h00000046);
        max_len = 70;
        run_case(8'h59, DA_OWN, 74, 0, 0, RFF_R_CRC_REJECT);
        wr(`RFF_OFF_CTRL, 32'h59);
        // The counter word is read-only, so this write must change nothing.
        wr(`RFF_OFF_COUNT, 32'hFFFFFFFF);
        rdc("counters", `RFF_OFF_COUNT, {n_drop[15:0], n_acc[15:0]},
            '1, 1'b0);
        stop_test();
    end

endmodule : rff_top_test

`default_nettype wire
